/* rtl/timer_pkg.sv */
// Register map, field positions and constants of the auto-reload timer
package timer_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [9:0] IDX_CONTROL = 10'h091;
    localparam logic [9:0] IDX_RELOAD_LOW = 10'h092;
    localparam logic [9:0] IDX_RELOAD_HIGH = 10'h093;
    localparam logic [9:0] IDX_COUNT_LOW = 10'h094;
    localparam logic [9:0] IDX_COUNT_HIGH = 10'h095;
    localparam logic [9:0] IDX_CLOCK_CONTROL = 10'h096;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_HIGH_FLAG = 7;
    localparam int BIT_LOW_FLAG = 6;
    localparam int BIT_LOW_IRQ_EN = 5;
    localparam int BIT_CAPTURE_EN = 4;
    localparam int BIT_SPLIT = 3;
    localparam int BIT_RUN = 2;
    localparam int BIT_SEL_HI = 1;
    localparam int BIT_SEL_LO = 0;
    localparam int BIT_HIGH_CHOICE = 1;
    localparam int BIT_LOW_CHOICE = 0;

    // ------------------------------------------------------------
    // Reset values and byte constants
    // ------------------------------------------------------------
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] BYTE_MAX = 8'hff;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // ------------------------------------------------------------
    // Clock select codes and divider ratios
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SEL_SYS_DIV12 = 2'b00,
        SEL_EXT_DIV8 = 2'b01,
        SEL_RESERVED = 2'b10,
        SEL_RTC = 2'b11
    } clk_sel_t;

    localparam int SYS_DIVIDE = 12;
    localparam int EXT_DIVIDE = 8;

endpackage : timer_pkg

/* rtl/pin_sync.sv */
// Two-flop synchroniser with rising-edge pulse for an asynchronous pin
`timescale 1ns/1ps
module pin_sync (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Pin and result
    input wire logic pin,
    output logic rise
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            meta_reg <= pin;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    // The second stage and its one-cycle delayed copy feed the edge detector
    assign rise = sync_reg & ~last_reg;
endmodule : pin_sync

/* rtl/tick_divider.sv */
// Divides a stream of one-cycle ticks by a fixed ratio
`timescale 1ns/1ps
module tick_divider #(
    parameter int RATIO = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Ticks in and out
    input wire logic tick_in,
    output logic tick_out
);
    localparam int W = $clog2(RATIO);
    localparam logic [W-1:0] LAST = W'(RATIO - 1);
    localparam logic [W-1:0] ONE = W'(1);

    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    wire at_last = (cnt_reg == LAST);

    assign cnt_next = at_last ? '0 : cnt_reg + ONE;
    assign tick_out = tick_in & at_last;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cnt_reg <= '0;
        end else if (tick_in) begin
            cnt_reg <= cnt_next;
        end
    end
endmodule : tick_divider

/* rtl/timer3_control_and_reload.sv */
// Auto-reload 16-bit / dual 8-bit timer with capture, APB registers
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
module timer3_control_and_reload
    import timer_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Oscillator pins, asynchronous
    input wire logic ext_osc,
    input wire logic rtc_osc,
    // Interrupt
    input wire logic timer_irq_enable,
    output logic irq_request
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic high_flag_reg, low_flag_reg, low_irq_en_reg, capture_en_reg;
    logic split_reg, run_reg;
    logic [1:0] sel_reg;
    logic high_choice_reg, low_choice_reg;
    logic [7:0] reload_low_reg, reload_high_reg;
    logic [7:0] count_low_reg, count_high_reg;
    logic [31:0] prdata_reg;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire [9:0] idx = paddr[11:2];
    wire aligned = (paddr[1:0] == 2'b00);
    wire hit_ctl = aligned && (idx == IDX_CONTROL);
    wire hit_rll = aligned && (idx == IDX_RELOAD_LOW);
    wire hit_rlh = aligned && (idx == IDX_RELOAD_HIGH);
    wire hit_cl = aligned && (idx == IDX_COUNT_LOW);
    wire hit_ch = aligned && (idx == IDX_COUNT_HIGH);
    wire hit_ckc = aligned && (idx == IDX_CLOCK_CONTROL);
    wire mapped = hit_ctl | hit_rll | hit_rlh | hit_cl | hit_ch | hit_ckc;
    wire setup = psel & ~penable;
    wire access = psel & penable;
    wire wr = access & pwrite & mapped;
    wire wr_ctl = wr & hit_ctl;
    wire wr_rll = wr & hit_rll;
    wire wr_rlh = wr & hit_rlh;
    wire wr_cl = wr & hit_cl;
    wire wr_ch = wr & hit_ch;
    wire wr_ckc = wr & hit_ckc;
    wire [7:0] wbyte = pwdata[7:0];

    wire [7:0] ctl_byte = {high_flag_reg, low_flag_reg, low_irq_en_reg,
        capture_en_reg, split_reg, run_reg, sel_reg};
    wire [7:0] ckc_byte = {6'h00, high_choice_reg, low_choice_reg};
    wire [7:0] rd_byte =
        hit_ctl ? ctl_byte :
        hit_rll ? reload_low_reg :
        hit_rlh ? reload_high_reg :
        hit_cl ? count_low_reg :
        hit_ch ? count_high_reg :
        hit_ckc ? ckc_byte : RESET_BYTE;

    // No wait state: read data is sampled during setup into a flop
    assign pready = access;
    assign pslverr = access & ~mapped;
    assign prdata = prdata_reg;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            prdata_reg <= READ_ZERO;
        end else if (setup) begin
            prdata_reg <= {24'h000000, rd_byte};
        end
    end

    // ------------------------------------------------------------
    // Clock sources
    // ------------------------------------------------------------
    logic ext_rise, rtc_rise, ext_div8, sys_div12;

    pin_sync ext_sync (
        .mclk(mclk), .rst_n(rst_n), .pin(ext_osc), .rise(ext_rise)
    );
    pin_sync rtc_sync (
        .mclk(mclk), .rst_n(rst_n), .pin(rtc_osc), .rise(rtc_rise)
    );
    tick_divider #(.RATIO(EXT_DIVIDE)) ext_div (
        .mclk(mclk), .rst_n(rst_n), .tick_in(ext_rise), .tick_out(ext_div8)
    );
    tick_divider #(.RATIO(SYS_DIVIDE)) sys_div (
        .mclk(mclk), .rst_n(rst_n), .tick_in(1'b1), .tick_out(sys_div12)
    );

    // Reserved code yields neither a count tick nor a trigger
    wire ext_tick = (sel_reg == SEL_SYS_DIV12) ? sys_div12 :
        (sel_reg == SEL_EXT_DIV8) ? ext_div8 :
        (sel_reg == SEL_RTC) ? rtc_rise : 1'b0;
    wire trig = (sel_reg == SEL_SYS_DIV12) ? rtc_rise :
        (sel_reg == SEL_EXT_DIV8 || sel_reg == SEL_RTC) ? ext_div8 :
        1'b0;
    wire tick_h = high_choice_reg | ext_tick;
    wire tick_l = low_choice_reg | ext_tick;

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    wire low_max = (count_low_reg == BYTE_MAX);
    wire high_max = (count_high_reg == BYTE_MAX);
    wire step16 = ~split_reg & run_reg & tick_l;
    wire step_l = split_reg ? tick_l : step16;
    wire step_h = split_reg ? (run_reg & tick_h) : (step16 & low_max);
    wire ovf_l = step_l & low_max;
    wire ovf_h = step_h & high_max;
    wire wrap16 = ~split_reg & ovf_h;
    wire capture = capture_en_reg & trig;

    logic [7:0] count_low_next, count_high_next;
    assign count_low_next = wr_cl ? wbyte :
        (split_reg ? ovf_l : wrap16) ? reload_low_reg :
        step_l ? count_low_reg + 8'h01 : count_low_reg;
    assign count_high_next = wr_ch ? wbyte :
        ovf_h ? reload_high_reg :
        step_h ? count_high_reg + 8'h01 : count_high_reg;

    // Hardware set beats a software clear in the same cycle
    wire high_flag_next = ovf_h | capture |
        (wr_ctl ? wbyte[BIT_HIGH_FLAG] : high_flag_reg);
    wire low_flag_next = ovf_l |
        (wr_ctl ? wbyte[BIT_LOW_FLAG] : low_flag_reg);

    // A software write to a reload byte wins over a capture
    wire [7:0] reload_low_next = wr_rll ? wbyte :
        capture ? count_low_reg : reload_low_reg;
    wire [7:0] reload_high_next = wr_rlh ? wbyte :
        capture ? count_high_reg : reload_high_reg;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            high_flag_reg <= 1'b0;
            low_flag_reg <= 1'b0;
            low_irq_en_reg <= 1'b0;
            capture_en_reg <= 1'b0;
            split_reg <= 1'b0;
            run_reg <= 1'b0;
            sel_reg <= SEL_SYS_DIV12;
        end else begin
            high_flag_reg <= high_flag_next;
            low_flag_reg <= low_flag_next;
            if (wr_ctl) begin
                low_irq_en_reg <= wbyte[BIT_LOW_IRQ_EN];
                capture_en_reg <= wbyte[BIT_CAPTURE_EN];
                split_reg <= wbyte[BIT_SPLIT];
                run_reg <= wbyte[BIT_RUN];
                sel_reg <= wbyte[BIT_SEL_HI:BIT_SEL_LO];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            high_choice_reg <= 1'b0;
            low_choice_reg <= 1'b0;
            reload_low_reg <= RESET_BYTE;
            reload_high_reg <= RESET_BYTE;
            count_low_reg <= RESET_BYTE;
            count_high_reg <= RESET_BYTE;
        end else begin
            if (wr_ckc) begin
                high_choice_reg <= wbyte[BIT_HIGH_CHOICE];
                low_choice_reg <= wbyte[BIT_LOW_CHOICE];
            end
            reload_low_reg <= reload_low_next;
            reload_high_reg <= reload_high_next;
            count_low_reg <= count_low_next;
            count_high_reg <= count_high_next;
        end
    end

    // ------------------------------------------------------------
    // Interrupt request
    // ------------------------------------------------------------
    assign irq_request = timer_irq_enable &
        (high_flag_reg | (low_irq_en_reg & low_flag_reg));

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    low_irq_path_a: assert property (
        $rose(low_flag_reg) && low_irq_en_reg && timer_irq_enable
        |-> irq_request)
        else $error("low byte overflow did not request interrupt");

    capture_copy_a: assert property (
        capture && !wr && !wr_ctl
        |=> reload_low_reg == $past(count_low_reg)
            && reload_high_reg == $past(count_high_reg) && high_flag_reg)
        else $error("capture did not copy count");

    split_low_free_a: assert property (
        split_reg && !run_reg && tick_l && !wr_cl
        |=> count_low_reg == ($past(low_max) ? $past(reload_low_reg)
            : $past(count_low_reg) + 8'h01))
        else $error("low byte stalled in split mode");

    run_hold_a: assert property (
        !run_reg && !split_reg && !wr_cl && !wr_ch
        |=> $stable(count_low_reg) && $stable(count_high_reg))
        else $error("counter moved while stopped");

    wrap_reload_a: assert property (
        !split_reg && run_reg && tick_l && low_max && high_max
        && !wr_cl && !wr_ch
        |=> count_low_reg == $past(reload_low_reg)
            && count_high_reg == $past(reload_high_reg) && high_flag_reg)
        else $error("16-bit wrap did not reload");

    split_high_a: assert property (
        split_reg && run_reg && tick_h && high_max && !wr_ch
        |=> count_high_reg == $past(reload_high_reg) && high_flag_reg)
        else $error("high byte did not reload in split mode");

    flag_sticky_a: assert property (
        high_flag_reg && low_flag_reg && !wr_ctl
        |=> high_flag_reg && low_flag_reg)
        else $error("overflow flag cleared by hardware");

    reserved_code_a: assert property (
        sel_reg == SEL_RESERVED |-> !ext_tick && !trig)
        else $error("reserved select produced a clock");

    rtc_capture_a: assert property (
        capture_en_reg && sel_reg == SEL_SYS_DIV12 && rtc_rise && !wr
        |=> high_flag_reg)
        else $error("rtc edge did not capture");

    apb_answer_a: assert property (
        setup ##1 access |-> pready)
        else $error("access phase without ready");

    low_flag_set_a: assert property (
        ovf_l |=> low_flag_reg)
        else $error("low byte rollover did not set its flag");

    high_flag_set_a: assert property (
        ovf_h |=> high_flag_reg)
        else $error("high byte rollover did not set its flag");

    high_irq_path_a: assert property (
        high_flag_reg && timer_irq_enable |-> irq_request)
        else $error("high byte overflow did not request interrupt");

    split_high_gate_a: assert property (
        split_reg && !run_reg && !wr_ch |=> $stable(count_high_reg))
        else $error("high byte moved with run clear in split mode");

    split_shared_clk_a: assert property (
        split_reg && !low_choice_reg && ext_tick && !low_max && !wr_cl
        |=> count_low_reg == $past(count_low_reg) + 8'h01)
        else $error("low byte missed the shared external tick");

    reload_low_write_a: assert property (
        wr_rll |=> reload_low_reg == $past(wbyte))
        else $error("reload low byte write lost");

    reload_high_write_a: assert property (
        wr_rlh |=> reload_high_reg == $past(wbyte))
        else $error("reload high byte write lost");

    sys_div_period_a: assert property (
        sys_div12 |=> !sys_div12 ##11 sys_div12)
        else $error("system clock divider period wrong");

    ext_sync_path_a: assert property (
        ext_rise |-> $past(ext_osc, 2))
        else $error("external edge seen before two sync stages");

    rtc_sync_path_a: assert property (
        rtc_rise |-> $past(rtc_osc, 2))
        else $error("rtc edge seen before two sync stages");

endmodule : timer3_control_and_reload

/* sim/tb.sv */
// Self-checking bench for the auto-reload timer with APB registers
`timescale 1ns/1ps
`define CHECK(got, exp) begin total_checks++; if ((got) !== (exp)) begin \
    fail_count++; $display("wrong value at %0t: got %h expected %h", \
    $time, got, exp); end end
module tb;
    import timer_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic ext_osc = 1'b0;
    logic rtc_osc = 1'b0;
    logic timer_irq_enable = 1'b0;
    logic irq_request;
    int fail_count = 0;
    int total_checks = 0;
    logic [31:0] rd;
    logic err;
    logic [7:0] v;

    always #2 mclk = ~mclk;

    timer3_control_and_reload u_timer3_control_and_reload (
        .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_osc(ext_osc),
        .rtc_osc(rtc_osc), .timer_irq_enable(timer_irq_enable),
        .irq_request(irq_request)
    );

    // ------------------------------------------------------------
    // Bus and pin tasks
    // ------------------------------------------------------------
    function automatic logic [11:0] byte_addr(input logic [9:0] idx);
        byte_addr = {idx, 2'b00};
    endfunction : byte_addr

    function automatic logic [7:0] after_steps(input logic [7:0] start,
                                               input int n);
        after_steps = start + 8'(n);
    endfunction : after_steps

    // Waits for pready so a slower slave would still be met correctly
    task automatic apb_xfer(input logic [9:0] idx, input logic is_wr,
                            input logic [7:0] wd);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= is_wr;
        paddr <= byte_addr(idx);
        pwdata <= {24'h00_0000, wd};
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb_xfer

    task automatic wr(input logic [9:0] idx, input logic [7:0] wd);
        apb_xfer(idx, 1'b1, wd);
    endtask : wr

    task automatic rdr(input logic [9:0] idx);
        apb_xfer(idx, 1'b0, 8'h00);
    endtask : rdr

    task automatic set_count(input logic [7:0] hi, input logic [7:0] lo);
        wr(IDX_COUNT_HIGH, hi);
        wr(IDX_COUNT_LOW, lo);
    endtask : set_count

    // Slow square wave, well inside what the two-flop sync can follow
    task automatic pulse_pins(input logic e, input logic r, input int n);
        repeat (n) begin
            @(posedge mclk);
            ext_osc <= e;
            rtc_osc <= r;
            repeat (4) @(posedge mclk);
            ext_osc <= 1'b0;
            rtc_osc <= 1'b0;
            repeat (3) @(posedge mclk);
        end
        repeat (8) @(posedge mclk);
    endtask : pulse_pins

    task automatic report_and_stop;
        if (fail_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        #(4 * 40000);
        fail_count++;
        report_and_stop();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        void'($urandom(1187));
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rdr(IDX_CONTROL + 10'(i));
            `CHECK(rd, READ_ZERO)
        end
        for (int i = 0; i < 4; i++) begin
            v = 8'($urandom);
            wr(IDX_RELOAD_LOW, v);
            wr(IDX_RELOAD_HIGH, ~v);
            rdr(IDX_RELOAD_LOW);
            `CHECK(rd, {24'h00_0000, v})
            rdr(IDX_RELOAD_HIGH);
            `CHECK(rd, {24'h00_0000, ~v})
        end
        rdr(10'h0a0);
        `CHECK({err, rd}, 33'h0_0000_0000 | 33'h1_0000_0000)
        // Held count while stopped, system clock every cycle
        wr(IDX_CLOCK_CONTROL, 8'h01);
        set_count(8'hff, 8'hf0);
        repeat (40) @(posedge mclk);
        rdr(IDX_COUNT_LOW);
        `CHECK(rd[7:0], 8'hf0)
        // 16-bit overflow reloads from both reload bytes
        wr(IDX_RELOAD_HIGH, 8'hff);
        wr(IDX_RELOAD_LOW, 8'h00);
        wr(IDX_CONTROL, 8'h04);
        repeat (40) @(posedge mclk);
        wr(IDX_CONTROL, 8'h80);
        rdr(IDX_COUNT_HIGH);
        `CHECK(rd[7:0], 8'hff)
        repeat (20) @(posedge mclk);
        rdr(IDX_CONTROL);
        `CHECK(rd[7], 1'b1)
        wr(IDX_CONTROL, 8'h00);
        rdr(IDX_CONTROL);
        `CHECK(rd[7:0], 8'h00)
        // Split mode: low byte counts with run clear, high byte holds
        wr(IDX_RELOAD_LOW, 8'ha0);
        wr(IDX_CONTROL, 8'h08);
        set_count(8'h33, 8'hf0);
        repeat (24) @(posedge mclk);
        rdr(IDX_COUNT_LOW);
        `CHECK(rd[7:5], 3'b101)
        rdr(IDX_COUNT_HIGH);
        `CHECK(rd[7:0], 8'h33)
        rdr(IDX_CONTROL);
        `CHECK(rd[7:6], 2'b01)
        timer_irq_enable <= 1'b1;
        repeat (2) @(posedge mclk);
        `CHECK(irq_request, 1'b0)
        wr(IDX_CONTROL, 8'h68);
        @(posedge mclk);
        `CHECK(irq_request, 1'b1)
        timer_irq_enable <= 1'b0;
        repeat (2) @(posedge mclk);
        `CHECK(irq_request, 1'b0)
        timer_irq_enable <= 1'b1;
        wr(IDX_CONTROL, 8'h00);
        @(posedge mclk);
        `CHECK(irq_request, 1'b0)
        // External sources: ext/8, real-time osc, reserved code
        wr(IDX_CLOCK_CONTROL, 8'h00);
        set_count(8'h00, 8'h00);
        wr(IDX_CONTROL, 8'h05);
        pulse_pins(1'b1, 1'b0, 24);
        wr(IDX_CONTROL, 8'h00);
        rdr(IDX_COUNT_LOW);
        `CHECK(rd[7:0], 8'h03)
        set_count(8'h00, 8'h00);
        wr(IDX_CONTROL, 8'h07);
        pulse_pins(1'b0, 1'b1, 5);
        wr(IDX_CONTROL, 8'h00);
        rdr(IDX_COUNT_LOW);
        `CHECK(rd[7:0], 8'h05)
        set_count(8'h00, 8'h00);
        wr(IDX_CONTROL, 8'h06);
        pulse_pins(1'b1, 1'b1, 16);
        wr(IDX_CONTROL, 8'h00);
        rdr(IDX_COUNT_LOW);
        `CHECK(rd[7:0], 8'h00)
        // System clock divided by 12 over 123 cycles of run
        set_count(8'h00, 8'h00);
        wr(IDX_CONTROL, 8'h04);
        repeat (120) @(posedge mclk);
        wr(IDX_CONTROL, 8'h00);
        rdr(IDX_COUNT_LOW);
        `CHECK(rd[7:0] >= 8'h09 && rd[7:0] <= 8'h0b, 1'b1)
        // Capture on ext/8 while counting every system clock
        wr(IDX_CLOCK_CONTROL, 8'h01);
        wr(IDX_RELOAD_LOW, 8'h00);
        wr(IDX_RELOAD_HIGH, 8'h00);
        set_count(8'h00, 8'h00);
        wr(IDX_CONTROL, 8'h15);
        pulse_pins(1'b1, 1'b0, 8);
        rdr(IDX_CONTROL);
        `CHECK(rd[7], 1'b1)
        wr(IDX_CONTROL, 8'h00);
        rdr(IDX_RELOAD_HIGH);
        `CHECK(rd[7:0], 8'h00)
        rdr(IDX_RELOAD_LOW);
        `CHECK(rd[7:0] > 8'h20 && rd[7:0] < 8'h70, 1'b1)
        // Split mode, high byte on the system clock for 23 run edges
        wr(IDX_CLOCK_CONTROL, 8'h02);
        set_count(8'h10, 8'h00);
        wr(IDX_CONTROL, 8'h0c);
        repeat (20) @(posedge mclk);
        wr(IDX_CONTROL, 8'h00);
        rdr(IDX_COUNT_HIGH);
        `CHECK(rd[7:0], after_steps(8'h10, 23))
        report_and_stop();
    end
endmodule : tb
